// ### pea_host.sv
// APB-controlled host that drives a byte-wide EEPROM through its pins
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "pea_defines.svh"
module pea_host #(
   parameter int ERASE_CYC = `PEA_ERASE_CYC,
   parameter int PUW_CYC = `PEA_PUW_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] byte_io_in,
   input wire logic done_flag_pin_in,
   output pea_pkg::pea_pins_t pins
);

   localparam logic [17:0] ACC_WAIT = 18'(`PEA_ACC_CYC + `PEA_SYNC_STAGES);
   localparam logic [17:0] WP_LAST = 18'(`PEA_WP_CYC - 1);
   localparam logic [17:0] HIZ_LAST = 18'(`PEA_HIZ_CYC - 1);
   localparam logic [17:0] ERS_LAST = 18'(`PEA_ERS_CYC - 1);
   localparam logic [10:0] BLC_LIMIT = 11'(`PEA_BLC_CYC - `PEA_BLC_GUARD_CYC);
   localparam logic [10:0] BLC_DRAIN = 11'(`PEA_BLC_CYC + 2 * `PEA_BLC_GUARD_CYC);
   localparam logic [17:0] PUR_CNT = 18'(`PEA_PUR_CYC);

   logic [7:0] data_sync;
   logic ready_sync;

   pea_sync #(.W(8)) u_sync_data (
      .pclk(pclk),
      .presetn(presetn),
      .d(byte_io_in),
      .q(data_sync)
   );

   pea_sync #(.W(1)) u_sync_ready (
      .pclk(pclk),
      .presetn(presetn),
      .d(done_flag_pin_in),
      .q(ready_sync)
   );

   pea_pkg::pea_state_t st, next_st;
   logic [17:0] tmr, next_tmr;
   logic [10:0] blc, next_blc;
   logic [17:0] pu, next_pu;
   logic [12:0] addr, next_addr;
   logic [7:0] wdata, next_wdata;
   logic [7:0] rdata, next_rdata;
   logic [6:0] page_base, next_page_base;
   logic [6:0] nbytes, next_nbytes;
   logic page_open, next_page_open;
   logic refused, next_refused;
   logic poll_mode, next_poll_mode;
   logic poll_first, next_poll_first;
   logic prev6, next_prev6;
   logic prev6_older, next_prev6_older;
   logic [31:0] next_prdata;
   pea_pkg::pea_pins_t next_pins;

   logic wr_ok, rd_ok, acc_wr, cmd_go, refuse_now, clr_refused;
   logic [2:0] cmd;
   logic [31:0] status;

   // Slave answers every access with no wait state
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   always_comb
   begin
      wr_ok = (pu >= 18'(PUW_CYC));
      rd_ok = (pu >= PUR_CNT);
      acc_wr = psel && penable && pwrite;
      cmd = pwdata[2:0];
      cmd_go = acc_wr && (paddr == `PEA_REG_CTRL);
      clr_refused = acc_wr && (paddr == `PEA_REG_STATUS) && pwdata[`PEA_ST_REFUSED];
      status = 32'h0000_0000;
      status[`PEA_ST_BUSY] = (st != pea_pkg::ST_IDLE);
      status[`PEA_ST_READY] = ready_sync;
      status[`PEA_ST_PAGE] = page_open;
      status[`PEA_ST_REFUSED] = refused;
      status[`PEA_ST_WR_OK] = wr_ok;
      status[`PEA_ST_RD_OK] = rd_ok;
      status[`PEA_ST_NBYTES_LO +: 7] = nbytes;

      next_st = st;
      next_tmr = tmr + 18'h00001;
      next_blc = blc;
      next_pu = wr_ok ? pu : pu + 18'h00001;
      next_addr = addr;
      next_wdata = wdata;
      next_rdata = rdata;
      next_page_base = page_base;
      next_nbytes = nbytes;
      next_page_open = page_open;
      next_poll_mode = poll_mode;
      next_poll_first = poll_first;
      next_prev6 = prev6;
      refuse_now = 1'b0;

      if (acc_wr && (paddr == `PEA_REG_ADDR))
         next_addr = pwdata[12:0];
      if (acc_wr && (paddr == `PEA_REG_WDATA))
         next_wdata = pwdata[7:0];

      // Load timer runs from each latch; closing early by a guard keeps the next fall inside the window
      // Timer runs on past the close until the memory's own window has surely ended
      if (page_open || (blc != 11'h000))
         next_blc = blc + 11'h001;
      if (!page_open && (blc >= BLC_DRAIN))
         next_blc = 11'h000;
      if (page_open && (st == pea_pkg::ST_IDLE) && (blc >= BLC_LIMIT))
      begin
         next_page_open = 1'b0;
         next_nbytes = 7'h00;
      end

      if (cmd_go)
      begin
         if (st != pea_pkg::ST_IDLE)
            refuse_now = 1'b1;
         else
         begin
            unique case (cmd)
               `PEA_CMD_READ, `PEA_CMD_POLL:
               begin
                  if (!rd_ok)
                     refuse_now = 1'b1;
                  else
                  begin
                     next_st = pea_pkg::ST_RD_ACC;
                     next_poll_mode = (cmd == `PEA_CMD_POLL);
                     next_poll_first = 1'b1;
                  end
               end
               `PEA_CMD_WRITE:
               begin
                  // Lock and unlock codes go out as ordinary page writes
                  if (!wr_ok)
                     refuse_now = 1'b1;
                  else if (page_open && (addr[12:6] != page_base))
                     refuse_now = 1'b1;
                  else if (page_open && (nbytes == `PEA_PAGE_BYTES))
                     refuse_now = 1'b1;
                  else if (!page_open && (!ready_sync || (blc != 11'h000)))
                     refuse_now = 1'b1;
                  else
                     next_st = pea_pkg::ST_WR_SETUP;
               end
               `PEA_CMD_ERASE:
               begin
                  if (!wr_ok || page_open || !ready_sync || (blc != 11'h000))
                     refuse_now = 1'b1;
                  else
                     next_st = pea_pkg::ST_ER_SETUP;
               end
               default:
                  refuse_now = 1'b1;
            endcase
         end
      end

      unique case (st)
         pea_pkg::ST_IDLE:
         begin
         end
         pea_pkg::ST_RD_ACC:
         begin
            // Access time plus synchroniser delay before the byte is trusted
            if (tmr == ACC_WAIT)
            begin
               next_rdata = data_sync;
               next_prev6 = data_sync[6];
               next_st = pea_pkg::ST_RD_END;
            end
         end
         pea_pkg::ST_RD_END:
         begin
            if (tmr == HIZ_LAST)
            begin
               next_poll_first = 1'b0;
               if (poll_mode && (poll_first || (rdata[6] != prev6_older)))
                  next_st = pea_pkg::ST_RD_ACC;
               else
                  next_st = pea_pkg::ST_IDLE;
            end
         end
         pea_pkg::ST_WR_SETUP:
            next_st = pea_pkg::ST_WR_PULSE;
         pea_pkg::ST_WR_PULSE:
         begin
            if (tmr == WP_LAST)
            begin
               next_st = pea_pkg::ST_WR_HOLD;
               next_blc = 11'h000;
               next_page_open = 1'b1;
               next_nbytes = page_open ? nbytes + 7'h01 : 7'h01;
               if (!page_open)
                  next_page_base = addr[12:6];
            end
         end
         pea_pkg::ST_WR_HOLD:
            next_st = pea_pkg::ST_IDLE;
         pea_pkg::ST_ER_SETUP:
         begin
            if (tmr == ERS_LAST)
               next_st = pea_pkg::ST_ER_PULSE;
         end
         pea_pkg::ST_ER_PULSE:
         begin
            if (tmr == 18'(ERASE_CYC - 1))
               next_st = pea_pkg::ST_ER_HOLD;
         end
         pea_pkg::ST_ER_HOLD:
         begin
            if (tmr == ERS_LAST)
               next_st = pea_pkg::ST_IDLE;
         end
         default:
            next_st = pea_pkg::ST_IDLE;
      endcase

      if (next_st != st)
         next_tmr = 18'h00000;

      // A refusal in the same cycle as a clear still shows
      next_refused = refuse_now || (refused && !clr_refused);

      next_prdata = prdata;
      if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            `PEA_REG_ADDR: next_prdata = {19'h00000, addr};
            `PEA_REG_WDATA: next_prdata = {24'h000000, wdata};
            `PEA_REG_RDATA: next_prdata = {24'h000000, rdata};
            `PEA_REG_STATUS: next_prdata = status;
            default: next_prdata = 32'h0000_0000;
         endcase
      end

      // Pins follow the next state so they change right after the edge
      // Register writes during a cycle must not move the pins under a strobe
      next_pins.byte_location_bus = (st == pea_pkg::ST_IDLE) ? next_addr : pins.byte_location_bus;
      next_pins.byte_io_out = (st == pea_pkg::ST_IDLE) ? next_wdata : pins.byte_io_out;
      next_pins.byte_io_oe = (next_st == pea_pkg::ST_WR_SETUP) || (next_st == pea_pkg::ST_WR_PULSE)
                             || (next_st == pea_pkg::ST_WR_HOLD);
      next_pins.chip_on_n = (next_st == pea_pkg::ST_IDLE) || (next_st == pea_pkg::ST_RD_END);
      next_pins.output_on_n = (next_st != pea_pkg::ST_RD_ACC);
      next_pins.store_strobe_n = (next_st != pea_pkg::ST_WR_PULSE) && (next_st != pea_pkg::ST_ER_PULSE);
      next_pins.erase_hv_en = (next_st == pea_pkg::ST_ER_SETUP) || (next_st == pea_pkg::ST_ER_PULSE)
                              || (next_st == pea_pkg::ST_ER_HOLD);
   end

   // Bit 6 of the read before the latest one
   always_comb
   begin
      next_prev6_older = prev6_older;
      if ((st == pea_pkg::ST_RD_ACC) && (tmr == ACC_WAIT))
         next_prev6_older = prev6;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= pea_pkg::ST_IDLE;
         tmr <= 18'h00000;
         blc <= 11'h000;
         pu <= 18'h00000;
         addr <= `PEA_RST_ADDR;
         wdata <= `PEA_RST_BYTE;
         rdata <= `PEA_RST_BYTE;
         page_base <= 7'h00;
         nbytes <= 7'h00;
         page_open <= 1'b0;
         refused <= 1'b0;
         poll_mode <= 1'b0;
         poll_first <= 1'b0;
         prev6 <= 1'b0;
         prev6_older <= 1'b0;
         prdata <= 32'h0000_0000;
         pins <= '{byte_location_bus: 13'h0000, byte_io_out: 8'h00, byte_io_oe: 1'b0, chip_on_n: 1'b1,
                   output_on_n: 1'b1, store_strobe_n: 1'b1, erase_hv_en: 1'b0};
      end
      else
      begin
         st <= next_st;
         tmr <= next_tmr;
         blc <= next_blc;
         pu <= next_pu;
         addr <= next_addr;
         wdata <= next_wdata;
         rdata <= next_rdata;
         page_base <= next_page_base;
         nbytes <= next_nbytes;
         page_open <= next_page_open;
         refused <= next_refused;
         poll_mode <= next_poll_mode;
         poll_first <= next_poll_first;
         prev6 <= next_prev6;
         prev6_older <= next_prev6_older;
         prdata <= next_prdata;
         pins <= next_pins;
      end
   end

endmodule : pea_host

// ### pea_defines.svh
// Constants for the parallel EEPROM host controller
`ifndef PEA_DEFINES_SVH
`define PEA_DEFINES_SVH

`define PEA_CLK_NS 50

// APB register byte offsets
`define PEA_REG_CTRL 12'h000
`define PEA_REG_ADDR 12'h004
`define PEA_REG_WDATA 12'h008
`define PEA_REG_RDATA 12'h00c
`define PEA_REG_STATUS 12'h010

// Command codes in CTRL[2:0]
`define PEA_CMD_READ 3'h1
`define PEA_CMD_WRITE 3'h2
`define PEA_CMD_ERASE 3'h3
`define PEA_CMD_POLL 3'h4

// STATUS bit positions
`define PEA_ST_BUSY 0
`define PEA_ST_READY 1
`define PEA_ST_PAGE 2
`define PEA_ST_REFUSED 3
`define PEA_ST_WR_OK 4
`define PEA_ST_RD_OK 5
`define PEA_ST_NBYTES_LO 8

// Reset values
`define PEA_RST_ADDR 13'h0000
`define PEA_RST_BYTE 8'h00

// Device timing figures
`define PEA_ACC_NS 150
`define PEA_WP_NS 50
`define PEA_HIZ_NS 50
`define PEA_BLC_US 100
`define PEA_ERS_SETUP_US 5
`define PEA_ERASE_MS 10
`define PEA_PUW_MS 10
`define PEA_PUR_US 1
`define PEA_PAGE_BYTES 7'd64
`define PEA_SYNC_STAGES 2

// Cycle counts: least times round up, longest times round down
`define PEA_ACC_CYC ((`PEA_ACC_NS + `PEA_CLK_NS - 1) / `PEA_CLK_NS)
`define PEA_WP_CYC ((`PEA_WP_NS + `PEA_CLK_NS - 1) / `PEA_CLK_NS)
`define PEA_HIZ_CYC ((`PEA_HIZ_NS + `PEA_CLK_NS - 1) / `PEA_CLK_NS)
`define PEA_BLC_CYC ((`PEA_BLC_US * 1000) / `PEA_CLK_NS)
`define PEA_BLC_GUARD_CYC 4
`define PEA_ERS_CYC ((`PEA_ERS_SETUP_US * 1000 + `PEA_CLK_NS - 1) / `PEA_CLK_NS)
`define PEA_ERASE_CYC ((`PEA_ERASE_MS * 1000000 + `PEA_CLK_NS - 1) / `PEA_CLK_NS)
`define PEA_PUW_CYC ((`PEA_PUW_MS * 1000000 + `PEA_CLK_NS - 1) / `PEA_CLK_NS)
`define PEA_PUR_CYC ((`PEA_PUR_US * 1000 + `PEA_CLK_NS - 1) / `PEA_CLK_NS)

`endif

// ### pea_pkg.sv
// Types for the parallel EEPROM host controller
package pea_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_RD_ACC,
      ST_RD_END,
      ST_WR_SETUP,
      ST_WR_PULSE,
      ST_WR_HOLD,
      ST_ER_SETUP,
      ST_ER_PULSE,
      ST_ER_HOLD
   } pea_state_t;

   // Pins driven toward the memory
   typedef struct packed {
      logic [12:0] byte_location_bus;
      logic [7:0] byte_io_out;
      logic byte_io_oe;
      logic chip_on_n;
      logic output_on_n;
      logic store_strobe_n;
      logic erase_hv_en;
   } pea_pins_t;

endpackage : pea_pkg

// ### pea_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module pea_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] stage1;
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_q;

   always_comb
   begin
      next_stage1 = d;
      next_q = stage1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage1 <= '0;
         q <= '0;
      end
      else
      begin
         stage1 <= next_stage1;
         q <= next_q;
      end
   end

endmodule : pea_sync

// ### pea_host_checker.sv
// Pin and bus assertions for the EEPROM host
`timescale 1ns/100ps
module pea_host_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pready,
   input wire logic pslverr,
   input wire pea_pkg::pea_pins_t pins
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_apb_answer: assert property (pready && !pslverr) else $error("apb answer wrong");
   a_read_strobes: assert property (!pins.output_on_n |-> pins.store_strobe_n)
      else $error("output and store strobes low together");
   a_read_length: assert property ($fell(pins.output_on_n) |-> !pins.chip_on_n [*4])
      else $error("read cycle cut short");
   a_drive_release: assert property (pins.byte_io_oe |-> pins.output_on_n)
      else $error("host drives data while output enabled");
   a_write_start: assert property ($fell(pins.store_strobe_n) |-> !pins.chip_on_n && pins.output_on_n)
      else $error("store strobe fell outside a write");
   a_addr_hold: assert property (!pins.chip_on_n && $past(!pins.chip_on_n) |-> $stable(pins.byte_location_bus))
      else $error("address moved while selected");
   a_data_hold: assert property ($rose(pins.store_strobe_n) && !pins.erase_hv_en |->
      pins.byte_io_oe && $stable(pins.byte_io_out) && !pins.chip_on_n)
      else $error("write data not held through latch");
   a_erase_chip: assert property (pins.erase_hv_en && !pins.store_strobe_n |-> !pins.chip_on_n)
      else $error("erase pulse without chip select");
   a_erase_len: assert property ($fell(pins.store_strobe_n) && pins.erase_hv_en |=> !pins.store_strobe_n [*8])
      else $error("erase pulse too short");
   c_write: cover property ($rose(pins.store_strobe_n) && !pins.erase_hv_en);
   c_read: cover property ($fell(pins.output_on_n));
   c_erase: cover property ($rose(pins.erase_hv_en));
endmodule : pea_host_checker

bind pea_host pea_host_checker i_chk (.pclk(pclk), .presetn(presetn), .pready(pready), .pslverr(pslverr),
   .pins(pins));

// ### pea_mem_model.sv
// Behavioural byte-wide EEPROM seen from its pins
`timescale 1ns/100ps
module pea_mem_model #(
   parameter int BLC_CYC = 2000,
   parameter int WC_CYC = 200,
   parameter int ER_CYC = 20
) (
   input wire logic pclk,
   input wire pea_pkg::pea_pins_t pins,
   input wire logic [7:0] din,
   output logic [7:0] dout,
   output logic dout_en,
   output logic busy_low
);
   logic [7:0] mem [0:8191];
   logic [12:0] pa [$];
   logic [7:0] pd [$];
   logic [12:0] la;
   logic [7:0] last_d = 8'h00;
   logic loading = 1'b0;
   logic prog = 1'b0;
   logic locked = 1'b0; // No reset reaches it, so the lock outlives power cycles
   logic tog = 1'b0;
   logic wr_act;
   int tmr = 0;
   int pc = 0;
   int ers = 0;
   // Shipped unlocked, so writes reach the array unless it is programming or the page already holds 64 bytes
   initial foreach (mem[i]) mem[i] = 8'hff;
   assign wr_act = !pins.chip_on_n && !pins.store_strobe_n && pins.output_on_n && !pins.erase_hv_en;
   assign dout_en = !pins.chip_on_n && !pins.output_on_n && pins.store_strobe_n && !pins.erase_hv_en;
   assign dout = (loading || prog) ? {~last_d[7], tog, !loading, last_d[4:0]} : mem[pins.byte_location_bus];
   assign busy_low = prog;
   always @(posedge wr_act) la = pins.byte_location_bus;
   always @(negedge wr_act)
   begin
      if (!prog && !locked && pd.size() < 64)
      begin
         pa.push_back(la);
         pd.push_back(din);
         last_d = din;
         loading = 1'b1;
         tmr = 0;
      end
   end
   always @(posedge pins.output_on_n) if (prog) tog = ~tog;
   always @(posedge pclk)
   begin
      ers = (pins.erase_hv_en && !pins.chip_on_n && !pins.store_strobe_n) ? ers + 1 : 0;
      tmr = loading ? tmr + 1 : 0;
      pc = prog ? pc - 1 : WC_CYC;
      if (loading && tmr >= BLC_CYC)
      begin
         loading = 1'b0;
         prog = 1'b1;
         tog = 1'b0;
      end
      else if (prog && pc == 0)
      begin
         while (pd.size() > 0) mem[pa.pop_front()] = pd.pop_front();
         prog = 1'b0;
      end
   end
   always @(posedge pins.store_strobe_n)
   begin
      if (pins.erase_hv_en && ers >= ER_CYC && !prog && !locked)
      begin
         foreach (mem[i]) mem[i] = 8'hff;
         prog = 1'b1;
         tog = 1'b0;
      end
   end
endmodule : pea_mem_model

// ### test_pea_host.sv
// Self-checking bench for the EEPROM host controller
`timescale 1ns/100ps
`include "pea_defines.svh"
module test_pea_host;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mden, mbusy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0] mdout, bus, d;
   logic [7:0] junk = 8'h5a;
   logic [12:0] a;
   logic [7:0] exp_mem [int];
   pea_pkg::pea_pins_t pins;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   int seed, i;
   pea_host #(.ERASE_CYC(20), .PUW_CYC(30)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .byte_io_in(bus), .done_flag_pin_in(!mbusy), .pins(pins));
   pea_mem_model #(.ER_CYC(20)) i_mem (.pclk(pclk), .pins(pins), .din(bus), .dout(mdout), .dout_en(mden),
      .busy_low(mbusy));
   // Released lines carry a moving pattern, never the last value
   assign bus = pins.byte_io_oe ? pins.byte_io_out : (mden ? mdout : junk);
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      junk <= junk + 8'h35;
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         final_report();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic idle;
      do apb(1'b0, `PEA_REG_STATUS, 32'h0); while (q[0] !== 1'b0);
   endtask : idle
   task automatic settle;
      do apb(1'b0, `PEA_REG_STATUS, 32'h0); while (q[1] !== 1'b0);
      do apb(1'b0, `PEA_REG_STATUS, 32'h0); while (q[1] !== 1'b1);
   endtask : settle
   task automatic wbyte(input logic [12:0] wa, input logic [7:0] wd);
      apb(1'b1, `PEA_REG_ADDR, {19'h0, wa});
      apb(1'b1, `PEA_REG_WDATA, {24'h0, wd});
      apb(1'b1, `PEA_REG_CTRL, {29'h0, `PEA_CMD_WRITE});
      idle();
   endtask : wbyte
   task automatic rbyte(input logic [12:0] ra);
      apb(1'b1, `PEA_REG_ADDR, {19'h0, ra});
      apb(1'b1, `PEA_REG_CTRL, {29'h0, `PEA_CMD_READ});
      idle();
      apb(1'b0, `PEA_REG_RDATA, 32'h0);
   endtask : rbyte
   task automatic final_report;
      $display("Checks %0d, errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report
   initial
   begin
      seed = 83;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `PEA_REG_STATUS, 32'h0);
      check(q & 32'h30, 32'h0);
      apb(1'b1, `PEA_REG_CTRL, {29'h0, `PEA_CMD_READ});
      apb(1'b0, `PEA_REG_STATUS, 32'h0);
      check({31'h0, q[3]}, 32'h1);
      apb(1'b1, `PEA_REG_STATUS, 32'h8);
      apb(1'b0, `PEA_REG_RDATA, 32'h0);
      check(q, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      check(q, 32'h0);
      repeat (40) @(posedge pclk);
      apb(1'b0, `PEA_REG_STATUS, 32'h0);
      check(q, 32'h32);
      apb(1'b1, `PEA_REG_CTRL, 32'h7);
      apb(1'b0, `PEA_REG_STATUS, 32'h0);
      check(q, 32'h3a);
      apb(1'b1, `PEA_REG_STATUS, 32'h8);
      for (i = 0; i < 64; i++)
      begin
         a = 13'h0140 + 13'(i);
         d = 8'($random(seed));
         exp_mem[a] = d;
         wbyte(a, d);
      end
      apb(1'b0, `PEA_REG_STATUS, 32'h0);
      check(q, 32'h4036);
      wbyte(13'h0150, 8'h00);
      apb(1'b0, `PEA_REG_STATUS, 32'h0);
      check(q, 32'h403e);
      apb(1'b1, `PEA_REG_STATUS, 32'h8);
      wbyte(13'h0200, 8'h11);
      apb(1'b0, `PEA_REG_STATUS, 32'h0);
      check(q, 32'h403e);
      apb(1'b1, `PEA_REG_STATUS, 32'h8);
      do apb(1'b0, `PEA_REG_STATUS, 32'h0); while (q[1] !== 1'b0);
      check({31'h0, q[2]}, 32'h0);
      rbyte(13'h017f);
      check({29'h0, q[7:5]}, {29'h0, ~exp_mem[13'h017f][7], 2'b01});
      rbyte(13'h017f);
      check({30'h0, q[6:5]}, 32'h3);
      apb(1'b1, `PEA_REG_CTRL, {29'h0, `PEA_CMD_POLL});
      idle();
      apb(1'b0, `PEA_REG_STATUS, 32'h0);
      check({31'h0, q[1]}, 32'h1);
      for (i = 0; i < 64; i++)
      begin
         rbyte(13'h0140 + 13'(i));
         check(q, {24'h0, exp_mem[13'h0140 + 13'(i)]});
      end
      apb(1'b1, `PEA_REG_CTRL, {29'h0, `PEA_CMD_ERASE});
      idle();
      do apb(1'b0, `PEA_REG_STATUS, 32'h0); while (q[1] !== 1'b1);
      for (i = 0; i < 8; i++)
      begin
         rbyte(13'h0140 + 13'(i * 8));
         check(q, 32'hff);
      end
      repeat (3)
      begin
         a = 13'($random(seed));
         d = 8'($random(seed));
         wbyte(a, d);
         settle();
         rbyte(a);
         check(q, {24'h0, d});
      end
      final_report();
   end
endmodule : test_pea_host
